// [inc/mhc_regs.vh]
// Register map, field layout, reset values and timing constants of the
// mirror heater and cleaner controller.
// Assumes a 200 MHz pclk and a 32-bit APB register bus.
`ifndef MHC_REGS_VH
`define MHC_REGS_VH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define MHC_A_CLN_CTRL 12'h000
`define MHC_A_CLN_WIN 12'h004
`define MHC_A_CLN_TIME 12'h008
`define MHC_A_HTR_CTRL 12'h00c
`define MHC_A_HTR_LOW 12'h010
`define MHC_A_HTR_WIN 12'h014
`define MHC_A_STATUS 12'h018

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define MHC_F_MODE 1:0
`define MHC_F_THR 14:8
`define MHC_F_PWR 14:8
`define MHC_F_OFS 23:16
`define MHC_F_START 10:0
`define MHC_F_STOP 26:16
`define MHC_F_REP 10:0
`define MHC_F_SPRAY 22:16
`define MHC_F_LTHR 6:0

// ----------------------------------------------------------------------
// Mode codes
// ----------------------------------------------------------------------
`define MHC_MODE_OFF 2'h0
`define MHC_MODE_ON 2'h1
`define MHC_MODE_AUTO 2'h2

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define MHC_RST_THR 7'h64
`define MHC_RST_REP 11'h002
`define MHC_RST_SPRAY 7'h3c
`define MHC_RST_PWR 7'h64
`define MHC_RST_OFS 8'h05
`define MHC_RST_LTHR 7'h64
`define MHC_RST_TIME 11'h000

// ----------------------------------------------------------------------
// Timing constants
// ----------------------------------------------------------------------
`define MHC_CLK_HZ 28'd200000000
`define MHC_TICK_SEC 28'd1
`define MHC_SPRAY_MAX 7'h6e
`define MHC_TAIL_SEC 7'h0a
`define MHC_SEC_LAST 6'h3b
`define MHC_PWM_LAST 7'h63
`define MHC_PWM_STEP 12'h7d0

`endif

// [src/mhc_window.v]
// Daily time window check on minute-of-day values.
// Assumes all three inputs count minutes since midnight.
`timescale 1ns/1ps
`include "mhc_regs.vh"

module mhc_window (
	input wire [10:0] now_min,
	input wire [10:0] start_min,
	input wire [10:0] stop_min,
	output reg in_win
);

	// Decides whether the current minute lies inside the window.
	always @* begin
		if (start_min == `MHC_RST_TIME && stop_min == `MHC_RST_TIME) begin
			in_win = 1'b1;
		end else if (start_min < stop_min) begin
			in_win = (now_min >= start_min) && (now_min < stop_min);
		end else if (stop_min < start_min) begin
			in_win = (now_min >= start_min) || (now_min < stop_min);
		end else begin
			in_win = 1'b0;
		end
	end

endmodule // mhc_window

// [src/mhc_ctrl.v]
// Mirror heater and self-cleaning controller with an APB register file.
// Assumes a time-of-day minute count, signal strength in percent and
// temperatures in whole degrees arrive synchronous to pclk.
//
// Overview of operation
// - A cycle runs pump and spin for the spray time, then spin alone 10 s.
// - Spray time is accepted in whole seconds from 0 to 110.
// - Zero spray with low signal skips the pump but still spins 10 s.
// - Cleaner mode is off, on or automatic; its settings act only in auto.
// - In auto a cycle starts when signal strength is below the threshold.
// - Cleaning only inside the daily window; 00:00 to 00:00 means all day.
// - Signal strength is rechecked every repeat interval, cleaning again.
// - Heaters receive the configured percentage of full power.
// - Only the upper mirror heats toward ambient plus offset.
// - In auto the lower heater runs only below its own signal threshold.
// - The heater window applies only in heater auto mode.
// - New settings act at once and are offered for non-volatile storage.
//
// Our own choices: the APB interface to the registers and the address map.
`timescale 1ns/1ps
`include "mhc_regs.vh"

module mhc_ctrl #(
	parameter [27:0] TICK_CYC = `MHC_CLK_HZ * `MHC_TICK_SEC,
	parameter [11:0] PWM_STEP_CYC = `MHC_PWM_STEP
) (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	input wire [10:0] tod_min,
	input wire [6:0] rssi_pct,
	input wire signed [7:0] ambient_degc,
	input wire signed [7:0] upper_mirror_degc,
	output reg pump_on,
	output reg spin_on,
	output reg heat_upper_on,
	output reg heat_lower_on,
	output reg cfg_store
);

	// ------------------------------------------------------------------
	// Cleaning cycle states
	// ------------------------------------------------------------------
	localparam [1:0] ST_IDLE = 2'h0;
	localparam [1:0] ST_SPRAY = 2'h1;
	localparam [1:0] ST_TAIL = 2'h2;

	reg [1:0] cln_mode_r;
	reg [6:0] cln_thr_r;
	reg [10:0] cln_start_r;
	reg [10:0] cln_stop_r;
	reg [10:0] cln_rep_r;
	reg [6:0] cln_spray_r;
	reg [1:0] htr_mode_r;
	reg [6:0] htr_pwr_r;
	reg [7:0] htr_ofs_r;
	reg [6:0] htr_lthr_r;
	reg [10:0] htr_start_r;
	reg [10:0] htr_stop_r;
	reg [1:0] state_r;
	reg [1:0] state_nxt;
	reg [6:0] cyc_cnt_r;
	reg [6:0] cyc_cnt_nxt;
	reg [27:0] div_r;
	reg tick_r;
	reg [5:0] sec_cnt_r;
	reg [10:0] min_cnt_r;
	reg [11:0] pwm_div_r;
	reg [6:0] pwm_cnt_r;
	reg [31:0] rd_nxt;
	reg rd_err_nxt;
	wire cln_win;
	wire htr_win;
	wire wr_en;
	wire acc;
	wire cln_auto;
	wire check_due;
	wire rssi_low;
	wire pwm_on;
	wire signed [9:0] upper_target;
	wire upper_cold;
	wire [6:0] spray_wr;

	// ------------------------------------------------------------------
	// APB slave
	// ------------------------------------------------------------------

	// Access phase without wait in progress; one wait state precedes pready.
	assign acc = psel && penable && !pready;
	// Writes take effect on the edge that sees pready high.
	assign wr_en = psel && penable && pready && pwrite;
	// Spray values above the maximum are clamped on write.
	assign spray_wr = (pwdata[`MHC_F_SPRAY] > `MHC_SPRAY_MAX) ?
		`MHC_SPRAY_MAX : pwdata[`MHC_F_SPRAY];

	// Read multiplexer with an error answer for unmapped offsets.
	always @* begin
		rd_nxt = 32'h0000_0000;
		rd_err_nxt = 1'b0;
		if (paddr == `MHC_A_CLN_CTRL) begin
			rd_nxt[`MHC_F_MODE] = cln_mode_r;
			rd_nxt[`MHC_F_THR] = cln_thr_r;
		end else if (paddr == `MHC_A_CLN_WIN) begin
			rd_nxt[`MHC_F_START] = cln_start_r;
			rd_nxt[`MHC_F_STOP] = cln_stop_r;
		end else if (paddr == `MHC_A_CLN_TIME) begin
			rd_nxt[`MHC_F_REP] = cln_rep_r;
			rd_nxt[`MHC_F_SPRAY] = cln_spray_r;
		end else if (paddr == `MHC_A_HTR_CTRL) begin
			rd_nxt[`MHC_F_MODE] = htr_mode_r;
			rd_nxt[`MHC_F_PWR] = htr_pwr_r;
			rd_nxt[`MHC_F_OFS] = htr_ofs_r;
		end else if (paddr == `MHC_A_HTR_LOW) begin
			rd_nxt[`MHC_F_LTHR] = htr_lthr_r;
		end else if (paddr == `MHC_A_HTR_WIN) begin
			rd_nxt[`MHC_F_START] = htr_start_r;
			rd_nxt[`MHC_F_STOP] = htr_stop_r;
		end else if (paddr == `MHC_A_STATUS) begin
			rd_nxt = {24'h00_0000, cln_win, htr_win, state_r,
				heat_lower_on, heat_upper_on, spin_on, pump_on};
		end else begin
			rd_err_nxt = 1'b1;
		end
	end

	// Bus answer flops: ready, read data and error.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else begin
			pready <= acc;
			if (acc) begin
				prdata <= pwrite ? 32'h0000_0000 : rd_nxt;
				pslverr <= rd_err_nxt;
			end else begin
				pslverr <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------------
	// Configuration registers
	// ------------------------------------------------------------------

	// Settings act from the cycle after the write and raise a store pulse.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cln_mode_r <= `MHC_MODE_OFF;
			cln_thr_r <= `MHC_RST_THR;
			cln_start_r <= `MHC_RST_TIME;
			cln_stop_r <= `MHC_RST_TIME;
			cln_rep_r <= `MHC_RST_REP;
			cln_spray_r <= `MHC_RST_SPRAY;
			htr_mode_r <= `MHC_MODE_OFF;
			htr_pwr_r <= `MHC_RST_PWR;
			htr_ofs_r <= `MHC_RST_OFS;
			htr_lthr_r <= `MHC_RST_LTHR;
			htr_start_r <= `MHC_RST_TIME;
			htr_stop_r <= `MHC_RST_TIME;
			cfg_store <= 1'b0;
		end else begin
			cfg_store <= wr_en && !rd_err_nxt &&
				(paddr != `MHC_A_STATUS);
			if (wr_en) begin
				if (paddr == `MHC_A_CLN_CTRL) begin
					cln_mode_r <= pwdata[`MHC_F_MODE];
					cln_thr_r <= pwdata[`MHC_F_THR];
				end else if (paddr == `MHC_A_CLN_WIN) begin
					cln_start_r <= pwdata[`MHC_F_START];
					cln_stop_r <= pwdata[`MHC_F_STOP];
				end else if (paddr == `MHC_A_CLN_TIME) begin
					cln_rep_r <= pwdata[`MHC_F_REP];
					cln_spray_r <= spray_wr;
				end else if (paddr == `MHC_A_HTR_CTRL) begin
					htr_mode_r <= pwdata[`MHC_F_MODE];
					htr_pwr_r <= pwdata[`MHC_F_PWR];
					htr_ofs_r <= pwdata[`MHC_F_OFS];
				end else if (paddr == `MHC_A_HTR_LOW) begin
					htr_lthr_r <= pwdata[`MHC_F_LTHR];
				end else if (paddr == `MHC_A_HTR_WIN) begin
					htr_start_r <= pwdata[`MHC_F_START];
					htr_stop_r <= pwdata[`MHC_F_STOP];
				end
			end
		end
	end

	// ------------------------------------------------------------------
	// Time base
	// ------------------------------------------------------------------

	// One-second enable pulse from the clock divider.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_r <= 28'h000_0000;
			tick_r <= 1'b0;
		end else if (div_r == TICK_CYC - 28'h000_0001) begin
			div_r <= 28'h000_0000;
			tick_r <= 1'b1;
		end else begin
			div_r <= div_r + 28'h000_0001;
			tick_r <= 1'b0;
		end
	end

	// Daily windows for the cleaner and the heaters.
	mhc_window u_cln_win (
		.now_min(tod_min),
		.start_min(cln_start_r),
		.stop_min(cln_stop_r),
		.in_win(cln_win)
	);

	mhc_window u_htr_win (
		.now_min(tod_min),
		.start_min(htr_start_r),
		.stop_min(htr_stop_r),
		.in_win(htr_win)
	);

	// ------------------------------------------------------------------
	// Repeat check interval
	// ------------------------------------------------------------------
	assign cln_auto = (cln_mode_r == `MHC_MODE_AUTO);
	assign rssi_low = (rssi_pct < cln_thr_r);
	// An interval of zero minutes behaves as one minute.
	assign check_due = tick_r && (sec_cnt_r == `MHC_SEC_LAST) &&
		(min_cnt_r + 11'h001 >= cln_rep_r);

	// Minute and second counters restart whenever auto mode is left.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sec_cnt_r <= 6'h00;
			min_cnt_r <= 11'h000;
		end else if (!cln_auto) begin
			sec_cnt_r <= 6'h00;
			min_cnt_r <= 11'h000;
		end else if (tick_r) begin
			if (sec_cnt_r == `MHC_SEC_LAST) begin
				sec_cnt_r <= 6'h00;
				if (check_due) begin
					min_cnt_r <= 11'h000;
				end else begin
					min_cnt_r <= min_cnt_r + 11'h001;
				end
			end else begin
				sec_cnt_r <= sec_cnt_r + 6'h01;
			end
		end
	end

	// ------------------------------------------------------------------
	// Cleaning cycle sequencer
	// ------------------------------------------------------------------

	// Next state: checks start cycles, seconds move spray and tail along.
	always @* begin
		state_nxt = state_r;
		cyc_cnt_nxt = cyc_cnt_r;
		if (!cln_auto) begin
			state_nxt = ST_IDLE;
			cyc_cnt_nxt = 7'h00;
		end else begin
			case (state_r)
			ST_IDLE: begin
				if (check_due && rssi_low && cln_win) begin
					cyc_cnt_nxt = 7'h00;
					if (cln_spray_r == 7'h00) begin
						state_nxt = ST_TAIL;
					end else begin
						state_nxt = ST_SPRAY;
					end
				end
			end
			ST_SPRAY: begin
				if (tick_r) begin
					if (cyc_cnt_r + 7'h01 >= cln_spray_r) begin
						state_nxt = ST_TAIL;
						cyc_cnt_nxt = 7'h00;
					end else begin
						cyc_cnt_nxt = cyc_cnt_r + 7'h01;
					end
				end
			end
			ST_TAIL: begin
				if (tick_r) begin
					if (cyc_cnt_r + 7'h01 >= `MHC_TAIL_SEC) begin
						state_nxt = ST_IDLE;
						cyc_cnt_nxt = 7'h00;
					end else begin
						cyc_cnt_nxt = cyc_cnt_r + 7'h01;
					end
				end
			end
			default: begin
				state_nxt = ST_IDLE;
				cyc_cnt_nxt = 7'h00;
			end
			endcase
		end
	end

	// Sequencer state and registered pump and spin drives.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_r <= ST_IDLE;
			cyc_cnt_r <= 7'h00;
			pump_on <= 1'b0;
			spin_on <= 1'b0;
		end else begin
			state_r <= state_nxt;
			cyc_cnt_r <= cyc_cnt_nxt;
			pump_on <= (state_nxt == ST_SPRAY);
			if (cln_mode_r == `MHC_MODE_ON) begin
				spin_on <= 1'b1;
			end else begin
				spin_on <= (state_nxt != ST_IDLE);
			end
		end
	end

	// ------------------------------------------------------------------
	// Heater power modulation
	// ------------------------------------------------------------------

	// Pulse-width counter of 100 steps; duty equals the power percent.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pwm_div_r <= 12'h000;
			pwm_cnt_r <= 7'h00;
		end else if (pwm_div_r == PWM_STEP_CYC - 12'h001) begin
			pwm_div_r <= 12'h000;
			if (pwm_cnt_r == `MHC_PWM_LAST) begin
				pwm_cnt_r <= 7'h00;
			end else begin
				pwm_cnt_r <= pwm_cnt_r + 7'h01;
			end
		end else begin
			pwm_div_r <= pwm_div_r + 12'h001;
		end
	end

	assign pwm_on = (pwm_cnt_r < htr_pwr_r);
	// Upper target is ambient plus offset, signed and wide enough not to wrap.
	assign upper_target = $signed({{2{ambient_degc[7]}}, ambient_degc}) +
		$signed({2'b00, htr_ofs_r});
	assign upper_cold = ($signed({{2{upper_mirror_degc[7]}},
		upper_mirror_degc}) < upper_target);

	// Heater drives per mode; window and signal test only in auto.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			heat_upper_on <= 1'b0;
			heat_lower_on <= 1'b0;
		end else if (htr_mode_r == `MHC_MODE_ON) begin
			heat_upper_on <= pwm_on && upper_cold;
			heat_lower_on <= pwm_on;
		end else if (htr_mode_r == `MHC_MODE_AUTO) begin
			heat_upper_on <= pwm_on && upper_cold && htr_win;
			heat_lower_on <= pwm_on && htr_win &&
				(rssi_pct < htr_lthr_r);
		end else begin
			heat_upper_on <= 1'b0;
			heat_lower_on <= 1'b0;
		end
	end

endmodule // mhc_ctrl

// [sim/mhc_asserts.sv]
// Port checker of the mirror heater and cleaner controller.
// Assumes it is bound to mhc_ctrl and sees only that module's ports.
`timescale 1ns/1ps

module mhc_chk #(
	parameter [27:0] TICK_CYC = 28'd20,
	parameter [11:0] PWM_STEP_CYC = 12'h002
) (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	input wire [31:0] prdata,
	input wire pready,
	input wire pslverr,
	input wire [10:0] tod_min,
	input wire [6:0] rssi_pct,
	input wire signed [7:0] ambient_degc,
	input wire signed [7:0] upper_mirror_degc,
	input wire pump_on,
	input wire spin_on,
	input wire heat_upper_on,
	input wire heat_lower_on,
	input wire cfg_store
);
	reg [31:0] pump_cnt_r;

	// Counts how long the pump has run without a break.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn)
			pump_cnt_r <= 32'h0;
		else if (pump_on)
			pump_cnt_r <= pump_cnt_r + 32'h1;
		else
			pump_cnt_r <= 32'h0;
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	apb_wait_state_a: assert property (psel && !penable |=> !pready ##1 pready)
		else $error("apb answer not after one wait state");
	ready_pulse_a: assert property (pready |=> !pready)
		else $error("pready held longer than one cycle");
	err_decode_a: assert property (pready |-> pslverr ==
		(paddr > 12'h018 || paddr[1:0] != 2'h0))
		else $error("pslverr does not match address decode");
	err_data_a: assert property (pready && pslverr && !pwrite |-> prdata == 0)
		else $error("refused read returned data");
	store_write_a: assert property (pready && pwrite && !pslverr &&
		paddr != 12'h018 |=> cfg_store)
		else $error("no store request after a settings write");
	store_cause_a: assert property ($rose(cfg_store) |->
		$past(pready) && $past(pwrite))
		else $error("store request without a write");
	pump_spin_a: assert property (pump_on |-> spin_on)
		else $error("pump runs without the spin motor");
	spin_tail_a: assert property ($fell(pump_on) && spin_on |->
		spin_on [*8])
		else $error("spin tail cut short");
	spray_limit_a: assert property (pump_cnt_r <= 32'd110 * TICK_CYC)
		else $error("pump ran past the spray ceiling");

	c_pump: cover property ($rose(pump_on));
	c_tail: cover property ($fell(pump_on) ##1 spin_on);
	c_err: cover property (pready && pslverr);
	c_lower: cover property ($rose(heat_lower_on));
endmodule // mhc_chk

// [sim/mhc_far_model.sv]
// Far side model: sensors, pump and spin motor of the mirror upkeep.
// Assumes the bench sets the scene; reports each drive run length.
`timescale 1ns/1ps

module mhc_far_model (
	input wire pclk,
	input wire pump_on,
	input wire spin_on,
	input wire [6:0] rssi_set,
	input wire signed [7:0] amb_set,
	input wire signed [7:0] mir_set,
	output reg [6:0] rssi_pct = 7'h00,
	output reg signed [7:0] ambient_degc = 8'sh00,
	output reg signed [7:0] upper_mirror_degc = 8'sh00,
	output reg [31:0] pump_len = 32'h0,
	output reg [31:0] spin_len = 32'h0,
	output reg pump_end = 1'b0,
	output reg spin_end = 1'b0
);
	reg [31:0] pc_r = 32'h0;
	reg [31:0] sc_r = 32'h0;

	// Sensors report the scene one cycle late, like a sampled reading.
	always @(posedge pclk) begin
		rssi_pct <= rssi_set;
		ambient_degc <= amb_set;
		upper_mirror_degc <= mir_set;
	end

	// Drive run lengths, reported in the cycle after each run ends.
	always @(posedge pclk) begin
		pump_end <= !pump_on && pc_r != 0;
		spin_end <= !spin_on && sc_r != 0;
		pump_len <= pc_r;
		spin_len <= sc_r;
		pc_r <= pump_on ? pc_r + 32'h1 : 32'h0;
		sc_r <= spin_on ? sc_r + 32'h1 : 32'h0;
	end
endmodule // mhc_far_model

// [sim/testbench.sv]
// Self-checking bench of the mirror heater and cleaner controller.
// Assumes mhc_ctrl, mhc_far_model and mhc_chk are compiled before it.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin \
n_mismatch++; $display("mismatch %s exp %h got %h", nm, e, g); end end

module testbench;
	localparam [27:0] T = 28'd20;
	localparam [11:0] P = 12'h002;
	reg pclk = 1'b0;
	reg presetn = 1'b0;
	reg psel = 1'b0;
	reg penable = 1'b0;
	reg pwrite = 1'b0;
	reg [11:0] paddr = 12'h000;
	reg [31:0] pwdata = 32'h0;
	reg [10:0] tod_min = 11'h000;
	reg [6:0] rssi_set = 7'h32;
	reg signed [7:0] amb_set = 8'sd20;
	reg signed [7:0] mir_set = 8'sd20;
	reg mon_en = 1'b1;
	reg [31:0] rnd = 32'h9f6c;
	reg [31:0] p;
	reg [31:0] e;
	integer n_mismatch = 0;
	integer checked = 0;
	reg [31:0] rq[$];
	reg [31:0] pq[$];
	reg [31:0] sq[$];
	wire [31:0] prdata, pump_len, spin_len;
	wire pready, pslverr, pump_on, spin_on, heat_upper_on, heat_lower_on;
	wire cfg_store, pump_end, spin_end;
	wire [6:0] rssi_pct;
	wire signed [7:0] ambient_degc, upper_mirror_degc;

	mhc_ctrl #(.TICK_CYC(T), .PWM_STEP_CYC(P)) DUT (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .tod_min(tod_min),
		.rssi_pct(rssi_pct), .ambient_degc(ambient_degc),
		.upper_mirror_degc(upper_mirror_degc), .pump_on(pump_on),
		.spin_on(spin_on), .heat_upper_on(heat_upper_on),
		.heat_lower_on(heat_lower_on), .cfg_store(cfg_store));

	mhc_far_model u_far (
		.pclk(pclk), .pump_on(pump_on), .spin_on(spin_on),
		.rssi_set(rssi_set), .amb_set(amb_set), .mir_set(mir_set),
		.rssi_pct(rssi_pct), .ambient_degc(ambient_degc),
		.upper_mirror_degc(upper_mirror_degc), .pump_len(pump_len),
		.spin_len(spin_len), .pump_end(pump_end), .spin_end(spin_end));

	// Clock of 5 ns period.
	always #2.5 pclk = ~pclk;

	function [31:0] xs(input [31:0] s);
		reg [31:0] x;
		begin
			x = s ^ (s << 13);
			x = x ^ (x >> 17);
			xs = x ^ (x << 5);
		end
	endfunction

	// One APB transfer, held until pready is sampled high.
	task apb(input [11:0] a, input w, input [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task rd(input [11:0] a, input [31:0] x);
		rq.push_back(x);
		apb(a, 1'b0, 32'h0);
	endtask

	task wr(input [11:0] a, input [31:0] d);
		apb(a, 1'b1, d);
	endtask

	// Re-enters a cleaner mode so the check interval restarts.
	task run(input [31:0] ctl, input integer n);
		wr(12'h000, 32'h0);
		wr(12'h000, ctl);
		repeat (n) @(posedge pclk);
	endtask

	// Counts heater drive cycles over one full PWM period after settling.
	task duty(input [31:0] eu, input [31:0] el);
		integer cu;
		integer cl;
		cu = 0;
		cl = 0;
		repeat (100 * P) @(posedge pclk);
		repeat (100 * P) begin
			@(posedge pclk);
			cu = cu + heat_upper_on;
			cl = cl + heat_lower_on;
		end
		`CHK("upper", eu, cu)
		`CHK("lower", el, cl)
	endtask

	task give_verdict;
		if (n_mismatch == 0 && checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// Compares read data and drive run lengths with the noted ones.
	always @(posedge pclk) begin
		if (psel && penable && pready && !pwrite) begin
			e = rq.pop_front();
			`CHK("prdata", e, prdata)
		end
		if (mon_en && pump_end === 1'b1) begin
			e = pq.size() ? pq.pop_front() : 32'h0;
			`CHK("pump run", e, pump_len)
		end
		if (mon_en && spin_end === 1'b1) begin
			e = sq.size() ? sq.pop_front() : 32'h0;
			`CHK("spin run", e, spin_len)
		end
	end

	// Cuts a hung run short.
	initial begin
		repeat (30000) @(posedge pclk);
		n_mismatch++;
		give_verdict;
	end

	// Main sequence.
	initial begin
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rd(12'h000, 32'h00006400);
		rd(12'h008, 32'h003c0002);
		rd(12'h00c, 32'h00056400);
		rd(12'h010, 32'h00000064);
		rd(12'h018, 32'h000000c0);
		rd(12'h020, 32'h0);
		wr(12'h008, 32'h007f0001);
		rd(12'h008, 32'h006e0001);
		wr(12'h008, 32'h00020001);
		rssi_set <= 7'd5;
		repeat (2) pq.push_back(2 * T);
		repeat (2) sq.push_back(12 * T);
		run(32'h00000a02, 136 * T);
		rssi_set <= 7'd50;
		run(32'h00000a02, 74 * T);
		wr(12'h008, 32'h00000001);
		rssi_set <= 7'd5;
		sq.push_back(10 * T);
		run(32'h00000a02, 74 * T);
		tod_min <= 11'd600;
		wr(12'h004, 32'h0078003c);
		run(32'h00000a02, 74 * T);
		wr(12'h004, 32'h02bc0564);
		sq.push_back(10 * T);
		run(32'h00000a02, 74 * T);
		`CHK("pending", 0, pq.size() + sq.size())
		mon_en <= 1'b0;
		wr(12'h000, 32'h00000001);
		repeat (4) @(posedge pclk);
		`CHK("spin on", 1'b1, spin_on)
		`CHK("pump on", 1'b0, pump_on)
		wr(12'h000, 32'h0);
		repeat (4) @(posedge pclk);
		`CHK("spin off", 1'b0, spin_on)
		repeat (3) begin
			rnd = xs(rnd);
			p = rnd % 101;
			wr(12'h00c, {16'h0005, 1'b0, p[6:0], 8'h01});
			mir_set <= 8'sd20;
			duty(2 * p, 2 * p);
			mir_set <= 8'sd30;
			duty(0, 2 * p);
		end
		mir_set <= 8'sd20;
		wr(12'h010, 32'h0000001e);
		wr(12'h00c, {16'h0005, 1'b0, p[6:0], 8'h02});
		rssi_set <= 7'd50;
		duty(2 * p, 0);
		rssi_set <= 7'd5;
		duty(2 * p, 2 * p);
		wr(12'h014, 32'h0078003c);
		duty(0, 0);
		wr(12'h00c, {16'h0005, 1'b0, p[6:0], 8'h01});
		duty(2 * p, 2 * p);
		wr(12'h00c, 32'h0);
		duty(0, 0);
		give_verdict;
	end
endmodule // testbench

bind mhc_ctrl mhc_chk #(.TICK_CYC(TICK_CYC), .PWM_STEP_CYC(PWM_STEP_CYC))
	u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .tod_min(tod_min),
	.rssi_pct(rssi_pct), .ambient_degc(ambient_degc),
	.upper_mirror_degc(upper_mirror_degc), .pump_on(pump_on),
	.spin_on(spin_on), .heat_upper_on(heat_upper_on),
	.heat_lower_on(heat_lower_on), .cfg_store(cfg_store));
